// file: switch_cfg_pkg.sv
// constants, field layout and config carrier of the global switch config bank
// assumes a 12-bit byte address and 16-bit data on the register port
package switch_cfg_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int MTU_W  = 14;
  localparam int DA_W   = 48;
  localparam int IDX_W  = 10;
  localparam int CNT_W  = 16;
  localparam int AGEP_W = 8;
  localparam int AGET_W = 11;

  localparam logic [11:0] OFF_MTU  = 12'h308;
  localparam logic [11:0] OFF_TPID = 12'h30a;
  localparam logic [11:0] OFF_LUE0 = 12'h310;

  localparam logic [13:0] MTU_RST   = 14'h07d0;
  localparam logic [13:0] MTU_JUMBO = 14'h2328;
  localparam logic [1:0]  MTU_RSVD_RST = 2'h0;
  localparam logic [15:0] TPID_RST  = 16'h9100;

  // lookup engine control zero layout
  localparam int VLAN_EN_BIT  = 7;
  localparam int DROP_VID_BIT = 6;
  localparam int AGE_MSB      = 5;
  localparam int AGE_LSB      = 3;
  localparam int RSVD_MC_BIT  = 2;
  localparam int HASH_MSB     = 1;
  localparam int HASH_LSB     = 0;

  localparam logic       VLAN_EN_RST  = 1'b0;
  localparam logic       DROP_VID_RST = 1'b1;
  localparam logic [2:0] AGE_RST      = 3'h4;
  localparam logic       RSVD_MC_RST  = 1'b0;
  localparam logic [1:0] HASH_RST     = 2'h1;

  localparam logic [1:0] HASH_DIRECT_LO = 2'h0;
  localparam logic [1:0] HASH_CRC       = 2'h1;
  localparam logic [1:0] HASH_XOR       = 2'h2;
  localparam logic [1:0] HASH_DIRECT_HI = 2'h3;

  // crc generator for the dynamic table index
  localparam logic [9:0] CRC_POLY = 10'h233;

  typedef struct packed {
    logic [1:0]  mtuRsvd;
    logic [13:0] mtu;
    logic [15:0] tpid;
    logic        vlanEn;
    logic        dropInvalidVid;
    logic [2:0]  ageCount;
    logic        rsvdMcastEn;
    logic [1:0]  hashSel;
  } cfg_s;

  localparam cfg_s CFG_RST = '{
    mtuRsvd:        MTU_RSVD_RST,
    mtu:            MTU_RST,
    tpid:           TPID_RST,
    vlanEn:         VLAN_EN_RST,
    dropInvalidVid: DROP_VID_RST,
    ageCount:       AGE_RST,
    rsvdMcastEn:    RSVD_MC_RST,
    hashSel:        HASH_RST
  };

endpackage : switch_cfg_pkg

// file: lookup_hash.sv
// dynamic address table index generator: direct, crc or xor fold
// purely combinational; the caller registers the result
module lookup_hash #(
  parameter int DA_W  = switch_cfg_pkg::DA_W,
  parameter int IDX_W = switch_cfg_pkg::IDX_W
) (
  input  wire logic [DA_W-1:0]  destAddr,
  input  wire logic [1:0]       lookupHashSelect,
  output logic      [IDX_W-1:0] index
);

  logic [IDX_W-1:0] crcIdx;
  logic [IDX_W-1:0] xorIdx;

  // crc shifts the address in msb first
  always_comb begin
    logic fb;
    fb = 1'b0;
    crcIdx = '0;
    for (int i = DA_W - 1; i >= 0; i--) begin
      fb = crcIdx[IDX_W-1] ^ destAddr[i];
      crcIdx = {crcIdx[IDX_W-2:0], 1'b0};
      if (fb) begin
        crcIdx = crcIdx ^ switch_cfg_pkg::CRC_POLY;
      end
    end
  end

  // xor folds every address bit onto index bit (position mod width)
  always_comb begin
    xorIdx = '0;
    for (int i = 0; i < DA_W; i++) begin
      xorIdx[i % IDX_W] = xorIdx[i % IDX_W] ^ destAddr[i];
    end
  end

  always_comb begin
    case (lookupHashSelect)
      switch_cfg_pkg::HASH_CRC: index = crcIdx;
      switch_cfg_pkg::HASH_XOR: index = xorIdx;
      default:                  index = destAddr[IDX_W-1:0];
    endcase
  end

endmodule : lookup_hash

// file: switch_frame_vlan_lookup_config.sv
// global config bank: payload length limit, outer tag type, lookup control zero
// assumes synchronous inputs from the forwarding datapath and one-cycle strobes
// How it works
// - 14-bit payload length limit, read/write, resets to 2000.
// - payload bytes beyond the programmed limit are cut off.
// - limits up to 9000 are stored and honoured for jumbo frames.
// - 16-bit outer tag type, resets to 0x9100, used for default and outer tags.
// - master vlan enable, clear at reset, gates vlan forwarding and filtering.
// - drop bit set (reset one): packets with invalid vlan id are discarded.
// - drop bit clear: invalid vlan id packets go to the host port.
// - unknown vlan id forwarding, when enabled, overrides the drop bit.
// - 3-bit age count, reset 100b, written into each updated dynamic entry.
// - aging time comes from age count combined with the age period.
// - reserved multicast table enable, clear at reset.
// - hash select 00 or 11 indexes by the ten low destination bits.
// - hash select 01 (reset) uses crc, 10 uses xor.
// - soft reset returns every field here to its default.
module switch_frame_vlan_lookup_config #(
  parameter int ADDR_W = switch_cfg_pkg::ADDR_W,
  parameter int DATA_W = switch_cfg_pkg::DATA_W,
  parameter int DA_W   = switch_cfg_pkg::DA_W,
  parameter int IDX_W  = switch_cfg_pkg::IDX_W
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic              softReset,
  input  wire logic              frameStart,
  input  wire logic              payloadValid,
  output logic                   payloadPass,
  output logic                   truncated,
  output logic [15:0]            frameTagType,
  output logic                   frameVlanEn,
  output logic                   frameRsvdMcastEn,
  input  wire logic              vidCheck,
  input  wire logic              vidInvalid,
  input  wire logic              unknownVidFwdEn,
  output logic                   vidDrop,
  output logic                   vidToHost,
  input  wire logic              lookupReq,
  input  wire logic [DA_W-1:0]   destAddr,
  output logic                   lookupValid,
  output logic [IDX_W-1:0]       lookupIndex,
  input  wire logic              entryUpdate,
  output logic                   entryAgeWrite,
  output logic [2:0]             entryAgeCount,
  input  wire logic [switch_cfg_pkg::AGEP_W-1:0] agePeriod,
  output logic [switch_cfg_pkg::AGET_W-1:0]      agingTime
);

  switch_cfg_pkg::cfg_s cfg;
  switch_cfg_pkg::cfg_s frameCfg;
  switch_cfg_pkg::cfg_s effCfg;
  logic [switch_cfg_pkg::CNT_W-1:0] byteCount;
  logic [switch_cfg_pkg::CNT_W-1:0] limit;
  logic [IDX_W-1:0]                 next_index;
  logic [7:0]                       lue0;
  logic                             bytePasses;

  wire wrMtu  = regWr && (regAddr == switch_cfg_pkg::OFF_MTU);
  wire wrTpid = regWr && (regAddr == switch_cfg_pkg::OFF_TPID);
  wire wrLue0 = regWr && (regAddr == switch_cfg_pkg::OFF_LUE0);

  // soft reset outranks a write landing in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= switch_cfg_pkg::CFG_RST;
    end else if (softReset) begin
      cfg <= switch_cfg_pkg::CFG_RST;
    end else begin
      if (wrMtu) begin
        // full 14 bits kept so jumbo limits survive
        cfg.mtu     <= regWdata[switch_cfg_pkg::MTU_W-1:0];
        cfg.mtuRsvd <= regWdata[15:14];
      end
      if (wrTpid) begin
        cfg.tpid <= regWdata;
      end
      if (wrLue0) begin
        cfg.vlanEn         <= regWdata[switch_cfg_pkg::VLAN_EN_BIT];
        cfg.dropInvalidVid <= regWdata[switch_cfg_pkg::DROP_VID_BIT];
        cfg.ageCount       <= regWdata[switch_cfg_pkg::AGE_MSB:switch_cfg_pkg::AGE_LSB];
        cfg.rsvdMcastEn    <= regWdata[switch_cfg_pkg::RSVD_MC_BIT];
        cfg.hashSel        <= regWdata[switch_cfg_pkg::HASH_MSB:switch_cfg_pkg::HASH_LSB];
      end
    end
  end

  always_comb begin
    lue0 = '0;
    lue0[switch_cfg_pkg::VLAN_EN_BIT]  = cfg.vlanEn;
    lue0[switch_cfg_pkg::DROP_VID_BIT] = cfg.dropInvalidVid;
    lue0[switch_cfg_pkg::AGE_MSB:switch_cfg_pkg::AGE_LSB] = cfg.ageCount;
    lue0[switch_cfg_pkg::RSVD_MC_BIT]  = cfg.rsvdMcastEn;
    lue0[switch_cfg_pkg::HASH_MSB:switch_cfg_pkg::HASH_LSB] = cfg.hashSel;
  end

  // read data stands for exactly one cycle; unmapped reads give zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        switch_cfg_pkg::OFF_MTU:  regRdata <= {cfg.mtuRsvd, cfg.mtu};
        switch_cfg_pkg::OFF_TPID: regRdata <= cfg.tpid;
        switch_cfg_pkg::OFF_LUE0: regRdata <= {8'h00, lue0};
        default:                  regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // a frame starting in the write cycle still sees the old value,
  // because cfg only changes at the edge that ends the write
  assign effCfg = frameStart ? cfg : frameCfg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frameCfg <= switch_cfg_pkg::CFG_RST;
    end else if (frameStart) begin
      frameCfg <= cfg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frameTagType     <= switch_cfg_pkg::TPID_RST;
      frameVlanEn      <= switch_cfg_pkg::VLAN_EN_RST;
      frameRsvdMcastEn <= switch_cfg_pkg::RSVD_MC_RST;
    end else begin
      frameTagType     <= effCfg.tpid;
      frameVlanEn      <= effCfg.vlanEn;
      frameRsvdMcastEn <= effCfg.rsvdMcastEn;
    end
  end

  // payload byte counter, restarted by each frame, saturating
  assign limit      = {2'h0, effCfg.mtu};
  assign bytePasses = (frameStart ? '0 : byteCount) < limit;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byteCount <= '0;
    end else if (frameStart) begin
      byteCount <= {{(switch_cfg_pkg::CNT_W-1){1'b0}}, payloadValid};
    end else if (payloadValid && (byteCount != '1)) begin
      byteCount <= byteCount + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      payloadPass <= 1'b0;
      truncated   <= 1'b0;
    end else begin
      payloadPass <= payloadValid && bytePasses;
      if (payloadValid && !bytePasses) begin
        truncated <= 1'b1;
      end else if (frameStart) begin
        truncated <= 1'b0;
      end
    end
  end

  // invalid vid verdict; nothing is said when vlan mode is off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vidDrop   <= 1'b0;
      vidToHost <= 1'b0;
    end else begin
      vidDrop   <= 1'b0;
      vidToHost <= 1'b0;
      if (vidCheck && vidInvalid && effCfg.vlanEn && !unknownVidFwdEn) begin
        vidDrop   <= effCfg.dropInvalidVid;
        vidToHost <= !effCfg.dropInvalidVid;
      end
    end
  end

  lookup_hash #(
    .DA_W  (DA_W),
    .IDX_W (IDX_W)
  ) u_hash (
    .destAddr         (destAddr),
    .lookupHashSelect (effCfg.hashSel),
    .index            (next_index)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lookupValid <= 1'b0;
      lookupIndex <= '0;
    end else begin
      lookupValid <= lookupReq;
      if (lookupReq) begin
        lookupIndex <= next_index;
      end
    end
  end

  // age count follows the live register: table upkeep is not per frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      entryAgeWrite <= 1'b0;
      entryAgeCount <= switch_cfg_pkg::AGE_RST;
      agingTime     <= '0;
    end else begin
      entryAgeWrite <= entryUpdate;
      if (entryUpdate) begin
        entryAgeCount <= cfg.ageCount;
      end
      agingTime <= switch_cfg_pkg::AGET_W'({8'h00, cfg.ageCount} *
                                           {3'h0, agePeriod});
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_mtu_write;
    regWr && !softReset && (regAddr == switch_cfg_pkg::OFF_MTU);
  endsequence

  sequence s_mtu_read;
    regRd && (regAddr == switch_cfg_pkg::OFF_MTU);
  endsequence

  // one idle cycle between write and read, as software usually leaves it
  sequence s_bus_quiet;
    !regWr && !softReset;
  endsequence

  a_mtu_write_read: assert property (
    (s_mtu_write ##1 s_bus_quiet ##1 (s_mtu_read and s_bus_quiet)) |=>
      regRdata[13:0] == $past(regWdata[13:0], 3))
    else $error("mtu read back differs from write");

  sequence s_tpid_write;
    regWr && !softReset && (regAddr == switch_cfg_pkg::OFF_TPID);
  endsequence

  sequence s_tpid_read;
    regRd && (regAddr == switch_cfg_pkg::OFF_TPID);
  endsequence

  a_tpid_write_read: assert property (
    (s_tpid_write ##1 s_bus_quiet ##1 (s_tpid_read and s_bus_quiet)) |=>
      regRdata == $past(regWdata, 3))
    else $error("tag type read back differs from write");

  sequence s_lue0_write;
    regWr && !softReset && (regAddr == switch_cfg_pkg::OFF_LUE0);
  endsequence

  sequence s_lue0_read;
    regRd && (regAddr == switch_cfg_pkg::OFF_LUE0);
  endsequence

  a_lue0_write_read: assert property (
    (s_lue0_write ##1 s_bus_quiet ##1 (s_lue0_read and s_bus_quiet)) |=>
      regRdata == {8'h00, $past(regWdata[7:0], 3)})
    else $error("lookup control read back differs from write");

  a_mtu_jumbo_kept: assert property (
    (s_mtu_write and (regWdata[13:0] == switch_cfg_pkg::MTU_JUMBO)) |=>
      cfg.mtu == switch_cfg_pkg::MTU_JUMBO)
    else $error("jumbo limit not stored");

  a_payload_cut: assert property (
    (payloadValid && !frameStart && (byteCount >= {2'h0, frameCfg.mtu})) |=>
      (!payloadPass && truncated))
    else $error("byte beyond limit passed");

  a_payload_in_limit: assert property (
    (frameStart && payloadValid && (cfg.mtu != '0)) |=> payloadPass)
    else $error("first byte of frame dropped");

  a_tag_type_frame: assert property (
    frameStart |=> frameTagType == $past(cfg.tpid))
    else $error("frame tag type not taken from register");

  a_frame_cfg_hold: assert property (
    (!frameStart && !softReset) |=> (frameCfg == $past(frameCfg)))
    else $error("frame settings moved mid-frame");

  sequence s_vid_bad;
    vidCheck && vidInvalid && effCfg.vlanEn && !unknownVidFwdEn;
  endsequence

  a_vid_drop: assert property (
    (s_vid_bad and effCfg.dropInvalidVid) |=> (vidDrop && !vidToHost))
    else $error("invalid vid not dropped");

  a_vid_host: assert property (
    (s_vid_bad and !effCfg.dropInvalidVid) |=> (vidToHost && !vidDrop))
    else $error("invalid vid not sent to host");

  a_vid_unknown_wins: assert property (
    (vidCheck && unknownVidFwdEn) |=> !(vidDrop || vidToHost))
    else $error("unknown vid forwarding overridden");

  a_vlan_off_quiet: assert property (
    (vidCheck && !effCfg.vlanEn) |=> !(vidDrop || vidToHost))
    else $error("vid verdict while vlan mode off");

  a_age_write: assert property (
    entryUpdate |=> (entryAgeWrite && entryAgeCount == $past(cfg.ageCount)))
    else $error("age count not written on update");

  a_aging_time: assert property (
    1'b1 |=> agingTime == ($past(cfg.ageCount) * $past(agePeriod)))
    else $error("aging time mismatch");

  a_soft_reset_dflt: assert property (
    softReset |=> (cfg == switch_cfg_pkg::CFG_RST))
    else $error("soft reset left a field changed");

  a_rsvd_mcast_frame: assert property (
    frameStart |=> frameRsvdMcastEn == $past(cfg.rsvdMcastEn))
    else $error("reserved multicast enable not applied");

  a_hash_direct: assert property (
    (lookupReq && (effCfg.hashSel == switch_cfg_pkg::HASH_DIRECT_LO ||
                   effCfg.hashSel == switch_cfg_pkg::HASH_DIRECT_HI)) |=>
      (lookupValid && lookupIndex == $past(destAddr[IDX_W-1:0])))
    else $error("direct index not low address bits");

  a_hash_modes: assert property (
    (lookupReq && (effCfg.hashSel == switch_cfg_pkg::HASH_XOR)) |=>
      lookupIndex == ($past(destAddr[9:0]) ^ $past(destAddr[19:10]) ^
                      $past(destAddr[29:20]) ^ $past(destAddr[39:30]) ^
                      {2'h0, $past(destAddr[47:40])}))
    else $error("xor hash index wrong");

  a_trunc_clear: assert property (
    (frameStart && !payloadValid) |=> !truncated)
    else $error("truncation flag not cleared by new frame");

  a_frame_tag_hold: assert property (
    !frameStart |=> $stable(frameTagType))
    else $error("frame tag type moved mid-frame");

  a_vlan_en_frame: assert property (
    frameStart |=> frameVlanEn == $past(cfg.vlanEn))
    else $error("vlan enable not applied to frame");

  a_lookup_idle: assert property (
    !lookupReq |=> (!lookupValid && $stable(lookupIndex)))
    else $error("lookup answer without request");

  a_age_hold: assert property (
    !entryUpdate |=> (!entryAgeWrite && $stable(entryAgeCount)))
    else $error("age write without entry update");

endmodule : switch_frame_vlan_lookup_config

// file: tb_switch_frame_vlan_lookup_config.sv
// self-checking bench for the global switch config bank
// assumes the bench drives every port itself on the rising edge of clk
module tb_switch_frame_vlan_lookup_config;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rstn;
  logic [11:0] regAddr;
  logic [15:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdata;
  logic        softReset;
  logic        frameStart;
  logic        payloadValid;
  logic        payloadPass;
  logic        truncated;
  logic [15:0] frameTagType;
  logic        frameVlanEn;
  logic        frameRsvdMcastEn;
  logic        vidCheck;
  logic        vidInvalid;
  logic        unknownVidFwdEn;
  logic        vidDrop;
  logic        vidToHost;
  logic        lookupReq;
  logic [47:0] destAddr;
  logic        lookupValid;
  logic [9:0]  lookupIndex;
  logic        entryUpdate;
  logic        entryAgeWrite;
  logic [2:0]  entryAgeCount;
  logic [7:0]  agePeriod;
  logic [10:0] agingTime;
  int          n_mismatch = 0;
  int          compares   = 0;

  switch_frame_vlan_lookup_config i_switch_frame_vlan_lookup_config (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .softReset(softReset), .frameStart(frameStart),
    .payloadValid(payloadValid), .payloadPass(payloadPass), .truncated(truncated),
    .frameTagType(frameTagType), .frameVlanEn(frameVlanEn),
    .frameRsvdMcastEn(frameRsvdMcastEn), .vidCheck(vidCheck), .vidInvalid(vidInvalid),
    .unknownVidFwdEn(unknownVidFwdEn), .vidDrop(vidDrop), .vidToHost(vidToHost),
    .lookupReq(lookupReq), .destAddr(destAddr), .lookupValid(lookupValid),
    .lookupIndex(lookupIndex), .entryUpdate(entryUpdate), .entryAgeWrite(entryAgeWrite),
    .entryAgeCount(entryAgeCount), .agePeriod(agePeriod), .agingTime(agingTime)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic regWrite(input logic [11:0] addr, input logic [15:0] data);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= addr;
    regWdata <= data;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : regWrite

  // read data stand only in the cycle after the strobe, so sample just there
  task automatic regReadChk(input logic [11:0] addr, input logic [15:0] exp);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= addr;
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    check("regRdata", regRdata, exp);
  endtask : regReadChk

  // settings are snapshotted per frame, so a frame start follows each config change that a frame must see
  task automatic newFrame();
    @(posedge clk);
    frameStart <= 1'b1;
    @(posedge clk);
    frameStart <= 1'b0;
    #1;
  endtask : newFrame

  task automatic vidChk(input logic inv, input logic fwd, input logic expDrop,
                        input logic expHost);
    @(posedge clk);
    vidCheck        <= 1'b1;
    vidInvalid      <= inv;
    unknownVidFwdEn <= fwd;
    @(posedge clk);
    vidCheck <= 1'b0;
    #1;
    check("vidDrop", vidDrop, expDrop);
    check("vidToHost", vidToHost, expHost);
  endtask : vidChk

  function automatic logic [9:0] hashExp(input logic [1:0] sel, input logic [47:0] da);
    logic [9:0] crc;
    logic       fb;
    crc = 10'h000;
    case (sel)
      2'h1: begin
        for (int i = 47; i >= 0; i--) begin
          fb  = da[i] ^ crc[9];
          crc = {crc[8:0], 1'b0};
          if (fb) crc = crc ^ 10'h233;
        end
      end
      2'h2: crc = da[9:0] ^ da[19:10] ^ da[29:20] ^ da[39:30] ^ {2'h0, da[47:40]};
      default: crc = da[9:0];
    endcase
    return crc;
  endfunction : hashExp

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    rstn = 1'b0; regAddr = 12'h000; regWdata = 16'h0000; regWr = 1'b0; regRd = 1'b0;
    softReset = 1'b0; frameStart = 1'b0; payloadValid = 1'b0; vidCheck = 1'b0;
    vidInvalid = 1'b0; unknownVidFwdEn = 1'b0; lookupReq = 1'b0; destAddr = 48'h0;
    entryUpdate = 1'b0; agePeriod = 8'h0a;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    regReadChk(12'h308, 16'h07d0);
    regReadChk(12'h30a, 16'h9100);
    regReadChk(12'h310, 16'h0061);
    regReadChk(12'h30c, 16'h0000);
    regWrite(12'h308, 16'h2328);
    regReadChk(12'h308, 16'h2328);
    regWrite(12'h310, 16'hff61);
    regReadChk(12'h310, 16'h0061);
    newFrame();
    check("frameTagType", frameTagType, 16'h9100);
    regWrite(12'h30a, 16'h88a8);
    regReadChk(12'h30a, 16'h88a8);
    check("frameTagType", frameTagType, 16'h9100);
    // limit of two bytes: bytes 0 and 1 pass, bytes 2 and 3 are cut off
    regWrite(12'h308, 16'h0002);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      frameStart   <= (i == 0);
      payloadValid <= (i < 4);
      #1;
      if (i > 0) check("payloadPass", payloadPass, (i - 1) < 2);
      if (i == 1) check("frameTagType", frameTagType, 16'h88a8);
    end
    check("truncated", truncated, 1'b1);
    // no vlan table exists here, so the master enable may be set at once
    regWrite(12'h310, 16'h00e5);
    newFrame();
    check("truncated", truncated, 1'b0);
    check("frameVlanEn", frameVlanEn, 1'b1);
    check("frameRsvdMcastEn", frameRsvdMcastEn, 1'b1);
    vidChk(1'b1, 1'b0, 1'b1, 1'b0);
    vidChk(1'b0, 1'b0, 1'b0, 1'b0);
    vidChk(1'b1, 1'b1, 1'b0, 1'b0);
    regWrite(12'h310, 16'h00a1);
    newFrame();
    vidChk(1'b1, 1'b0, 1'b0, 1'b1);
    regWrite(12'h310, 16'h0061);
    newFrame();
    check("frameVlanEn", frameVlanEn, 1'b0);
    check("frameRsvdMcastEn", frameRsvdMcastEn, 1'b0);
    vidChk(1'b1, 1'b0, 1'b0, 1'b0);
    for (int s = 0; s < 4; s++) begin
      regWrite(12'h310, {14'h0018, s[1:0]});
      newFrame();
      @(posedge clk);
      lookupReq <= 1'b1;
      destAddr  <= 48'ha5c3_1e7f_9b2d ^ (48'h1111 * s);
      @(posedge clk);
      lookupReq <= 1'b0;
      #1;
      check("lookupValid", lookupValid, 1'b1);
      check("lookupIndex", lookupIndex, hashExp(s[1:0], destAddr));
    end
    regWrite(12'h310, 16'h0068);
    @(posedge clk);
    entryUpdate <= 1'b1;
    @(posedge clk);
    entryUpdate <= 1'b0;
    #1;
    check("entryAgeWrite", entryAgeWrite, 1'b1);
    check("entryAgeCount", entryAgeCount, 3'h5);
    repeat (3) @(posedge clk);
    #1;
    check("agingTime", agingTime, 11'd50);
    // a write landing beside the soft reset must lose
    @(posedge clk);
    softReset <= 1'b1;
    regWr     <= 1'b1;
    regAddr   <= 12'h308;
    regWdata  <= 16'h1234;
    @(posedge clk);
    softReset <= 1'b0;
    regWr     <= 1'b0;
    regReadChk(12'h308, 16'h07d0);
    regReadChk(12'h30a, 16'h9100);
    regReadChk(12'h310, 16'h0061);
    finish_test();
  end

endmodule : tb_switch_frame_vlan_lookup_config
